/* common/lpr_pkg.sv */
// Constants and types of the link parameter registers and error monitor
//
// Summary of operation
// - Converter count is 8-bit read/write, count minus one, reset 1.
// - Bits 7:5 hold subclass version, reset 1; sample bits set to 0xF.
// - Bits 7:5 hold protocol version, reset 1; samples code 1 is two.
// - The lane 0 checksum is 8-bit read/write and resets to 0x45.
// - A monitor write sets the selects and a read returns the counter.
// - Write-only lane select in bits 6:4 picks the lane read back.
// - Write-only counter select in bits 1:0 picks type; 00 is disparity.
// - A lane flag sets when its disparity count reaches a nonzero threshold.
package lpr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus and lane geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int LANES = 8;
   localparam int LANE_W = 3;
   localparam int CNT_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [11:0] OFS_CONV_COUNT = 12'h456;
   localparam logic [11:0] OFS_CTRL_RES = 12'h457;
   localparam logic [11:0] OFS_SUBCLASS_BITS = 12'h458;
   localparam logic [11:0] OFS_VERSION_SAMPLES = 12'h459;
   localparam logic [11:0] OFS_DENSITY_WORDS = 12'h45a;
   localparam logic [11:0] OFS_SPARE_ONE = 12'h45b;
   localparam logic [11:0] OFS_SPARE_TWO = 12'h45c;
   localparam logic [11:0] OFS_CHECKSUM = 12'h45d;
   localparam logic [11:0] OFS_ERR_MON = 12'h46b;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int POS_UPPER3_LO = 5; // version fields [7:5]
   localparam int POS_UPPER3_HI = 7;
   localparam int POS_LOW5_HI = 4;   // five-bit fields [4:0]
   localparam int POS_CTRL_BITS_LO = 6;
   localparam int POS_HD = 7;
   localparam int POS_LANE_SEL_LO = 4;
   localparam int POS_LANE_SEL_HI = 6;
   localparam int POS_CNTR_SEL_HI = 1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_CONV_COUNT = 8'h01;
   localparam logic [1:0] RST_CTRL_BITS = 2'h0;
   localparam logic [4:0] RST_RESOLUTION = 5'h0f;
   localparam logic [2:0] RST_SUBCLASS = 3'h1;
   localparam logic [4:0] RST_SAMPLE_BITS = 5'h0f;
   localparam logic [2:0] RST_VERSION = 3'h1;
   localparam logic [4:0] RST_SAMPLES = 5'h00;
   localparam logic RST_HD = 1'b1;
   localparam logic [4:0] RST_CTRL_WORDS = 5'h00;
   localparam logic [7:0] RST_SPARE = 8'h00;
   localparam logic [7:0] RST_CHECKSUM = 8'h45;
   localparam logic [7:0] RST_BYTE = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Counter select codes and counter arithmetic
   typedef enum logic [1:0] {
      CSEL_BAD_DISP = 2'h0,
      CSEL_TYPE1 = 2'h1,
      CSEL_TYPE2 = 2'h2,
      CSEL_TYPE3 = 2'h3
   } lpr_cntr_sel_t;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] THR_OFF = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Register bank state
   typedef struct packed {
      logic [7:0] conv_count;
      logic [1:0] ctrl_bits;
      logic [4:0] resolution;
      logic [2:0] subclass_version;
      logic [4:0] sample_bits_minus_one;
      logic [2:0] protocol_version;
      logic [4:0] samples_minus_one;
      logic high_density_format;
      logic [4:0] control_words_per_frame;
      logic [7:0] spare_one;
      logic [7:0] spare_two;
      logic [7:0] lane0_checksum_value;
      logic [2:0] lane_select;
      lpr_cntr_sel_t counter_type_select;
      logic [7:0] rdata;
      logic rvalid;
   } lpr_bank_t;

   // Error monitor state
   typedef struct packed {
      logic [LANES-1:0][CNT_W-1:0] bad_disparity_counter;
      logic [LANES-1:0] bad_disparity_flag;
   } lpr_mon_t;

endpackage

/* common/lpr_err_if.sv */
// Carrier between the register bank and the lane error monitor
interface lpr_err_if;
   import lpr_pkg::*;
   logic [LANES-1:0] bad_disp_event;
   logic [CNT_W-1:0] threshold;
   logic [LANES-1:0][CNT_W-1:0] counts;
   logic [LANES-1:0] flags;

   // Bank side drives events and threshold in
   modport bank (
      output bad_disp_event,
      output threshold,
      input counts,
      input flags
   );

   // Monitor side keeps counters and flags
   modport mon (
      input bad_disp_event,
      input threshold,
      output counts,
      output flags
   );
endinterface

/* design/lpr_err_mon.sv */
// Per-lane bad disparity counters and threshold flags
module lpr_err_mon
   import lpr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   lpr_err_if.mon err
);

   lpr_mon_t state_reg;
   lpr_mon_t state_next;
   logic [LANES-1:0][CNT_W-1:0] cnt_n;
   logic [LANES-1:0] flag_n;

   ////////////////////////////////////////////////////////////////////////
   // Per-lane saturating count and sticky flag
   genvar i;
   generate
      for (i = 0; i < LANES; i++)
      begin : g_lane
         assign cnt_n[i] = (err.bad_disp_event[i] &&
                            state_reg.bad_disparity_counter[i] != CNT_MAX) ?
                           CNT_W'(state_reg.bad_disparity_counter[i] + CNT_ONE)
                           : state_reg.bad_disparity_counter[i];
         // Flag sticks once the count reaches a nonzero threshold
         assign flag_n[i] = state_reg.bad_disparity_flag[i] ||
                            (err.threshold != THR_OFF &&
                             cnt_n[i] >= err.threshold);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      state_next = state_reg;
      state_next.bad_disparity_counter = cnt_n;
      state_next.bad_disparity_flag = flag_n;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign err.counts = state_reg.bad_disparity_counter;
   assign err.flags = state_reg.bad_disparity_flag;

endmodule

/* design/lpr_param_regs.sv */
// Link parameter register bank with lane error counter read-back
module lpr_param_regs
   import lpr_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [lpr_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [lpr_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [lpr_pkg::DATA_W-1:0] REG_RDATA,
   output logic REG_RDVALID,
   input wire logic [lpr_pkg::LANES-1:0] BAD_DISP_EVENT,
   input wire logic [lpr_pkg::CNT_W-1:0] ERR_THRESHOLD,
   output logic [lpr_pkg::LANES-1:0] BAD_DISP_FLAGS,
   output logic [7:0] CONVERTER_COUNT,
   output logic [1:0] CONTROL_BITS,
   output logic [4:0] RESOLUTION,
   output logic [2:0] SUBCLASS_VERSION,
   output logic [4:0] SAMPLE_BITS_MINUS_ONE,
   output logic [2:0] PROTOCOL_VERSION,
   output logic [4:0] SAMPLES_MINUS_ONE,
   output logic HIGH_DENSITY_FORMAT,
   output logic [4:0] CONTROL_WORDS_PER_FRAME,
   output logic [7:0] LANE0_CHECKSUM
);

   import lpr_pkg::*;

   lpr_bank_t state_reg;
   lpr_bank_t state_next;
   logic [1:0] rst_sync_reg;
   logic rst_n_int;
   lpr_err_if err ();

   ////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_sync_reg <= 2'h0;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n_int = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Lane error monitor
   assign err.bad_disp_event = BAD_DISP_EVENT;
   assign err.threshold = ERR_THRESHOLD;

   lpr_err_mon u_err_mon (
      .clk (CORE_CLK),
      .rst_n (rst_n_int),
      .err (err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Selected error counter, zero for undefined types
   function automatic logic [7:0] sel_count(
      input lpr_cntr_sel_t csel,
      input logic [2:0] lane,
      input logic [LANES-1:0][CNT_W-1:0] counts
   );
      logic [7:0] v;
      v = RST_BYTE;
      case (csel)
         CSEL_BAD_DISP: v = counts[lane];
         default: v = RST_BYTE;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register write decode
   always_comb
   begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      if (REG_WR)
      begin
         if (REG_ADDR == OFS_CONV_COUNT)
         begin
            state_next.conv_count = REG_WDATA;
         end
         else if (REG_ADDR == OFS_CTRL_RES)
         begin
            // Stored as written; software keeps both at their legal values
            state_next.ctrl_bits =
               REG_WDATA[POS_UPPER3_HI:POS_CTRL_BITS_LO];
            state_next.resolution = REG_WDATA[POS_LOW5_HI:0];
         end
         else if (REG_ADDR == OFS_SUBCLASS_BITS)
         begin
            state_next.subclass_version =
               REG_WDATA[POS_UPPER3_HI:POS_UPPER3_LO];
            state_next.sample_bits_minus_one =
               REG_WDATA[POS_LOW5_HI:0];
         end
         else if (REG_ADDR == OFS_VERSION_SAMPLES)
         begin
            state_next.protocol_version =
               REG_WDATA[POS_UPPER3_HI:POS_UPPER3_LO];
            state_next.samples_minus_one = REG_WDATA[POS_LOW5_HI:0];
         end
         else if (REG_ADDR == OFS_DENSITY_WORDS)
         begin
            state_next.high_density_format = REG_WDATA[POS_HD];
            state_next.control_words_per_frame =
               REG_WDATA[POS_LOW5_HI:0];
         end
         else if (REG_ADDR == OFS_SPARE_ONE)
         begin
            state_next.spare_one = REG_WDATA;
         end
         else if (REG_ADDR == OFS_SPARE_TWO)
         begin
            state_next.spare_two = REG_WDATA;
         end
         else if (REG_ADDR == OFS_CHECKSUM)
         begin
            state_next.lane0_checksum_value = REG_WDATA;
         end
         else if (REG_ADDR == OFS_ERR_MON)
         begin
            // Selects only; reserved bits are dropped
            state_next.lane_select =
               REG_WDATA[POS_LANE_SEL_HI:POS_LANE_SEL_LO];
            state_next.counter_type_select =
               lpr_cntr_sel_t'(REG_WDATA[POS_CNTR_SEL_HI:0]);
         end
      end

      // Register read decode; answer one cycle after the strobe
      if (REG_RD)
      begin
         state_next.rvalid = 1'b1;
         if (REG_ADDR == OFS_CONV_COUNT)
         begin
            state_next.rdata = state_reg.conv_count;
         end
         else if (REG_ADDR == OFS_CTRL_RES)
         begin
            state_next.rdata = {state_reg.ctrl_bits, 1'b0,
                                state_reg.resolution};
         end
         else if (REG_ADDR == OFS_SUBCLASS_BITS)
         begin
            state_next.rdata = {state_reg.subclass_version,
                                state_reg.sample_bits_minus_one};
         end
         else if (REG_ADDR == OFS_VERSION_SAMPLES)
         begin
            state_next.rdata = {state_reg.protocol_version,
                                state_reg.samples_minus_one};
         end
         else if (REG_ADDR == OFS_DENSITY_WORDS)
         begin
            state_next.rdata = {state_reg.high_density_format, 2'h0,
                                state_reg.control_words_per_frame};
         end
         else if (REG_ADDR == OFS_SPARE_ONE)
         begin
            state_next.rdata = state_reg.spare_one;
         end
         else if (REG_ADDR == OFS_SPARE_TWO)
         begin
            state_next.rdata = state_reg.spare_two;
         end
         else if (REG_ADDR == OFS_CHECKSUM)
         begin
            state_next.rdata = state_reg.lane0_checksum_value;
         end
         else if (REG_ADDR == OFS_ERR_MON)
         begin
            // Counter chosen by the current selects
            state_next.rdata = sel_count(state_reg.counter_type_select,
                                         state_reg.lane_select,
                                         err.counts);
         end
         else
         begin
            state_next.rdata = RST_BYTE; // Unmapped reads as zero
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register with documented reset values
   always_ff @(posedge CORE_CLK or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         state_reg <= '0;
         state_reg.conv_count <= RST_CONV_COUNT;
         state_reg.ctrl_bits <= RST_CTRL_BITS;
         state_reg.resolution <= RST_RESOLUTION;
         state_reg.subclass_version <= RST_SUBCLASS;
         state_reg.sample_bits_minus_one <= RST_SAMPLE_BITS;
         state_reg.protocol_version <= RST_VERSION;
         state_reg.samples_minus_one <= RST_SAMPLES;
         state_reg.high_density_format <= RST_HD;
         state_reg.control_words_per_frame <= RST_CTRL_WORDS;
         state_reg.spare_one <= RST_SPARE;
         state_reg.spare_two <= RST_SPARE;
         state_reg.lane0_checksum_value <= RST_CHECKSUM;
         state_reg.lane_select <= '0;
         state_reg.counter_type_select <= CSEL_BAD_DISP;
         state_reg.rdata <= RST_BYTE;
         state_reg.rvalid <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs from the state flops
   assign REG_RDATA = state_reg.rdata;
   assign REG_RDVALID = state_reg.rvalid;
   assign BAD_DISP_FLAGS = err.flags;
   assign CONVERTER_COUNT = state_reg.conv_count;
   assign CONTROL_BITS = state_reg.ctrl_bits;
   assign RESOLUTION = state_reg.resolution;
   assign SUBCLASS_VERSION = state_reg.subclass_version;
   assign SAMPLE_BITS_MINUS_ONE = state_reg.sample_bits_minus_one;
   assign PROTOCOL_VERSION = state_reg.protocol_version;
   assign SAMPLES_MINUS_ONE = state_reg.samples_minus_one;
   assign HIGH_DENSITY_FORMAT = state_reg.high_density_format;
   assign CONTROL_WORDS_PER_FRAME = state_reg.control_words_per_frame;
   assign LANE0_CHECKSUM = state_reg.lane0_checksum_value;

endmodule

/* verification/lpr_param_regs_asserts.sv */
// Port-level checks of the link parameter register bank
module lpr_param_regs_asserts
   import lpr_pkg::*;
(
   input logic CORE_CLK,
   input logic RST_N,
   input logic [11:0] REG_ADDR,
   input logic REG_WR,
   input logic [7:0] REG_WDATA,
   input logic REG_RD,
   input logic [7:0] REG_RDATA,
   input logic REG_RDVALID,
   input logic [7:0] BAD_DISP_EVENT,
   input logic [7:0] ERR_THRESHOLD,
   input logic [7:0] BAD_DISP_FLAGS,
   input logic [7:0] CONVERTER_COUNT,
   input logic [1:0] CONTROL_BITS,
   input logic [4:0] RESOLUTION,
   input logic [2:0] SUBCLASS_VERSION,
   input logic [4:0] SAMPLE_BITS_MINUS_ONE,
   input logic [2:0] PROTOCOL_VERSION,
   input logic [4:0] SAMPLES_MINUS_ONE,
   input logic HIGH_DENSITY_FORMAT,
   input logic [4:0] CONTROL_WORDS_PER_FRAME,
   input logic [7:0] LANE0_CHECKSUM
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] csel_reg;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////
   // Counter type last written to the monitor address
   always_ff @(posedge CORE_CLK or negedge RST_N)
      if (!RST_N)
         csel_reg <= 2'h0;
      else if (REG_WR && REG_ADDR == OFS_ERR_MON)
         csel_reg <= REG_WDATA[1:0];
   // Request shapes
   sequence wr_at(logic [11:0] a);
      REG_WR && REG_ADDR == a;
   endsequence
   sequence rd_req;
      REG_RD;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Field storage
   conv_write_a: assert property (wr_at(OFS_CONV_COUNT)
      |=> CONVERTER_COUNT == $past(REG_WDATA)) else $error("conv count");
   ctrl_res_write_a: assert property (wr_at(OFS_CTRL_RES)
      |=> {CONTROL_BITS, RESOLUTION}
      == $past({REG_WDATA[7:6], REG_WDATA[4:0]}))
      else $error("ctrl bits or resolution");
   subclass_write_a: assert property (wr_at(OFS_SUBCLASS_BITS)
      |=> {SUBCLASS_VERSION, SAMPLE_BITS_MINUS_ONE} == $past(REG_WDATA))
      else $error("subclass or sample bits");
   version_write_a: assert property (wr_at(OFS_VERSION_SAMPLES)
      |=> {PROTOCOL_VERSION, SAMPLES_MINUS_ONE} == $past(REG_WDATA))
      else $error("version or samples");
   density_write_a: assert property (wr_at(OFS_DENSITY_WORDS)
      |=> {HIGH_DENSITY_FORMAT, CONTROL_WORDS_PER_FRAME}
      == $past({REG_WDATA[7], REG_WDATA[4:0]})) else $error("density");
   checksum_write_a: assert property (wr_at(OFS_CHECKSUM)
      |=> LANE0_CHECKSUM == $past(REG_WDATA)) else $error("checksum");
   // Read answers
   read_answer_a: assert property (rd_req |=> REG_RDVALID)
      else $error("read answer");
   rdvalid_cause_a: assert property (REG_RDVALID |-> $past(REG_RD))
      else $error("read valid without request");
   other_type_a: assert property (rd_req ##0 REG_ADDR == OFS_ERR_MON
      && csel_reg != 2'h0 |=> REG_RDATA == 8'h00) else $error("other type");
   // Flags rise only on an event with a live threshold, then stay
   flag_cause_a: assert property (
      |(BAD_DISP_FLAGS & ~$past(BAD_DISP_FLAGS))
      |-> $past(ERR_THRESHOLD) != 8'h00 && (BAD_DISP_FLAGS
      & ~$past(BAD_DISP_FLAGS) & ~$past(BAD_DISP_EVENT)) == 8'h00)
      else $error("flag cause");
   flag_sticky_a: assert property (
      ($past(BAD_DISP_FLAGS) & ~BAD_DISP_FLAGS) == 8'h00) else $error("flag");
endmodule
bind lpr_param_regs lpr_param_regs_asserts u_lpr_param_regs_asserts (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .REG_RDVALID(REG_RDVALID),
   .BAD_DISP_EVENT(BAD_DISP_EVENT), .ERR_THRESHOLD(ERR_THRESHOLD),
   .BAD_DISP_FLAGS(BAD_DISP_FLAGS), .CONVERTER_COUNT(CONVERTER_COUNT),
   .CONTROL_BITS(CONTROL_BITS), .RESOLUTION(RESOLUTION),
   .SUBCLASS_VERSION(SUBCLASS_VERSION),
   .SAMPLE_BITS_MINUS_ONE(SAMPLE_BITS_MINUS_ONE),
   .PROTOCOL_VERSION(PROTOCOL_VERSION), .SAMPLES_MINUS_ONE(SAMPLES_MINUS_ONE),
   .HIGH_DENSITY_FORMAT(HIGH_DENSITY_FORMAT),
   .CONTROL_WORDS_PER_FRAME(CONTROL_WORDS_PER_FRAME),
   .LANE0_CHECKSUM(LANE0_CHECKSUM)
);

/* verification/lpr_tx_model.sv */
// Behavioural transmitter side raising lane bad disparity errors
module lpr_tx_model (
   input logic clk,
   input logic en,
   input logic [7:0] mask,
   input logic [7:0] solid,
   output logic [7:0] events
);
   timeunit 1ns;
   timeprecision 100ps;
   integer seed = 32'hfb5a022b;
   initial events = 8'h00;
   // One error per lane per cycle at most, launched just after the edge
   always @(posedge clk)
      events <= #1 en ? ((8'($random(seed)) & mask) | solid) : 8'h00;
endmodule

/* verification/lpr_param_regs_tb_top.sv */
// Self-checking bench for the link parameter register bank
module lpr_param_regs_tb_top
   import lpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] RSTV [8] = '{8'h01, 8'h0f, 8'h2f, 8'h20, 8'h80,
      8'h00, 8'h00, 8'h45};
   localparam logic [7:0] MASKS [8] = '{8'hff, 8'hdf, 8'hff, 8'hff, 8'h9f,
      8'hff, 8'hff, 8'hff};
   localparam logic [7:0] LEGAL [5] = '{8'h00, 8'h0f, 8'h2f, 8'h21, 8'h80};
   logic clk = 1'b0;
   logic rst_n;
   logic [11:0] addr = 12'h000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic en = 1'b0;
   logic [7:0] wdata = 8'h00, thr = 8'h00, mask = 8'h00, solid = 8'h00;
   logic [7:0] rdata, flags, ev, conv, csum, mflags;
   logic [4:0] res, sbits, smp, cwords;
   logic [2:0] subv, ver;
   logic [1:0] cbits;
   logic rdv, hd;
   logic [7:0] mdl [8];
   int cnt [8];
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   integer seed = 32'hfb5a022b;
   ////////////////////////////////////////////////////////////////////////
   // Design, far side and clock
   lpr_param_regs u_lpr_param_regs (.CORE_CLK(clk), .RST_N(rst_n),
      .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
      .REG_RDATA(rdata), .REG_RDVALID(rdv), .BAD_DISP_EVENT(ev),
      .ERR_THRESHOLD(thr), .BAD_DISP_FLAGS(flags), .CONVERTER_COUNT(conv),
      .CONTROL_BITS(cbits), .RESOLUTION(res), .SUBCLASS_VERSION(subv),
      .SAMPLE_BITS_MINUS_ONE(sbits), .PROTOCOL_VERSION(ver),
      .SAMPLES_MINUS_ONE(smp), .HIGH_DENSITY_FORMAT(hd),
      .CONTROL_WORDS_PER_FRAME(cwords), .LANE0_CHECKSUM(csum));
   lpr_tx_model u_lpr_tx_model (.clk(clk), .en(en), .mask(mask),
      .solid(solid), .events(ev));
   initial forever #4 clk = ~clk;
   // Reference error counters and flags
   always @(posedge clk)
      for (int i = 0; i < 8; i++)
      begin
         if (ev[i] === 1'b1 && cnt[i] < 255)
            cnt[i]++;
         if (ev[i] === 1'b1 && thr != 0 && cnt[i] >= thr)
            mflags[i] = 1'b1;
      end
   // Hang limit
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic w, input logic r, input logic [11:0] a,
      input logic [7:0] d);
      wr = w;
      rd = r;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      op(1'b0, 1'b1, a, 8'h00);
      chk({7'h00, rdv}, 8'h01);
      chk(rdata, exp);
      chk(flags, mflags);
   endtask
   task automatic chk_cfg();
      chk(conv, mdl[0]);
      chk({cbits, 1'b0, res}, mdl[1]);
      chk({subv, sbits}, mdl[2]);
      chk({ver, smp}, mdl[3]);
      chk({hd, 2'b00, cwords}, mdl[4]);
      chk(csum, mdl[7]);
      for (int i = 0; i < 8; i++)
         rdc(12'h456 + 12'(i), mdl[i]);
      rdc(12'h460, 8'h00);
   endtask
   task automatic mon_scan();
      for (int l = 0; l < 8; l++)
         for (int c = 0; c < 4; c++)
         begin
            op(1'b1, 1'b0, OFS_ERR_MON, {1'b1, 3'(l), 2'b11, 2'(c)});
            rdc(OFS_ERR_MON, c == 0 ? 8'(cnt[l]) : 8'h00);
         end
      op(1'b0, 1'b0, 12'h000, 8'h00);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cnt = '{default: 0};
      mflags = 8'h00;
      mdl = RSTV;
      repeat (2) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [11:0] a;
      logic [7:0] d;
      do_reset();
      chk_cfg();
      for (int i = 0; i < 8; i++)
      begin
         a = 12'h456 + 12'(i);
         d = 8'($random(seed));
         op(1'b1, 1'b0, a, d);
         mdl[i] = d & MASKS[i];
         rdc(a, mdl[i]);
      end
      op(1'b1, 1'b0, 12'h460, 8'($random(seed)));
      for (int i = 1; i < 5; i++)
      begin
         op(1'b1, 1'b0, 12'h456 + 12'(i), LEGAL[i]);
         mdl[i] = LEGAL[i];
      end
      chk_cfg();
      op(1'b0, 1'b0, 12'h000, 8'h00);
      mask = 8'h7f;
      solid = 8'h01;
      en = 1'b1;
      repeat (40) @(posedge clk);
      #1;
      en = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      mon_scan();
      thr = 8'd60;
      en = 1'b1;
      repeat (300) @(posedge clk);
      #1;
      en = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      mon_scan();
      do_reset();
      chk_cfg();
      mon_scan();
      close_out();
   end
endmodule
